// [opfmt_pkg.sv]
// constants and types for the operand format unit
// assumes a single core clock domain; used by both design files
// Behaviour
// RL1: boolean true is one in bit 31
// RL2: compare result clears all bits below msb
// RL3: eight-bit immediate used directly by instructions
// RL4: zero-fill constant: field low, upper zeros
// RL5: high-half constant: field high, low kept
// RL6: ones-fill constant: field low, upper ones
// RL7: software pairs doubles in even/odd registers
// RL8: double normal uses implicit one, bias 1023
// RL9: nan is max exponent, nonzero fraction
// RL10: fraction msb set quiet, clear signaling
// RL11: signaling nan input raises invalid operation
// RL12: nan or invalid operation yields quiet nan
// RL13: generated nan is default, top two bits
// RL14: reserved-operand enable traps instead of nan
// RL15: max exponent zero fraction is signed infinity
// RL16: zero exponent nonzero fraction is denormal
// RL17: zero exponent zero fraction is zero; equal
// RL18: classification and constants are combinational
package opfmt_pkg;
  localparam int WORD_W      = 32;
  localparam int HALF_W      = 16;
  localparam int IMM_W       = 8;
  localparam int BOOL_BIT    = 31;
  localparam int SP_EXP_W    = 8;
  localparam int SP_FRAC_W   = 23;
  localparam int DP_EXP_W    = 11;
  localparam int DP_FRAC_W   = 52;
  localparam int SP_BIAS     = 127;
  localparam int DP_BIAS     = 1023;
  localparam logic [31:0] BOOL_TRUE  = 32'h8000_0000;
  localparam logic [31:0] BOOL_FALSE = 32'h0000_0000;
  localparam logic [31:0] SP_DEF_QUIET_NOT_A_NUMBER = 32'h7fe0_0000;
  localparam logic [63:0] DP_DEF_QUIET_NOT_A_NUMBER = 64'h7ffc_0000_0000_0000;
  localparam logic [31:0] RESULT_RST  = 32'h0000_0000;

  typedef enum logic [2:0]
  {
    CLS_ZERO,
    CLS_DENORMAL,
    CLS_NORMAL,
    CLS_INFINITY,
    CLS_QUIET_NAN,
    CLS_SIGNALING_NAN
  } fp_class_t;

  typedef enum logic [2:0]
  {
    OP_NONE,
    OP_COMPARE,
    OP_CONST_ZERO_FILL,
    OP_LOAD_HIGH_HALF_KEEP_LOW,
    OP_LOAD_LOW_HALF_ONES_FILL,
    OP_IMMEDIATE,
    OP_FLOAT
  } op_sel_t;
endpackage

// [fp_classifier.sv]
// ieee 754 operand classifier, parameterised by field widths
// assumes operands arrive already packed sign/exponent/fraction
`timescale 1ns/1ps
module fp_classifier #(
  parameter int EXP_W  = 8,
  parameter int FRAC_W = 23
)(
  input  wire logic [EXP_W+FRAC_W:0] operand,
  output opfmt_pkg::fp_class_t       op_class,
  output logic                       sign
);
  logic [EXP_W-1:0]  exp_f;
  logic [FRAC_W-1:0] frac_f;
  logic              exp_max;
  logic              exp_zero;
  logic              frac_zero;

  assign sign      = operand[EXP_W+FRAC_W];
  assign exp_f     = operand[EXP_W+FRAC_W-1:FRAC_W];
  assign frac_f    = operand[FRAC_W-1:0];
  assign exp_max   = &exp_f;
  assign exp_zero  = ~|exp_f;
  assign frac_zero = ~|frac_f;

  always_comb
  begin
    if (exp_max && !frac_zero)
    begin
      // sign ignored for nan [RL9]; fraction msb picks kind [RL10]
      op_class = frac_f[FRAC_W-1] ? opfmt_pkg::CLS_QUIET_NAN
                                  : opfmt_pkg::CLS_SIGNALING_NAN;
    end
    else if (exp_max)
      op_class = opfmt_pkg::CLS_INFINITY;   // [RL15]
    else if (exp_zero && !frac_zero)
      op_class = opfmt_pkg::CLS_DENORMAL;   // [RL16]
    else if (exp_zero)
      op_class = opfmt_pkg::CLS_ZERO;       // [RL17]
    else
      op_class = opfmt_pkg::CLS_NORMAL;     // implicit one [RL8]
  end
endmodule

// [operand_format_unit.sv]
// operand format unit: booleans, wide constants, fp classification
// assumes decoder presents op and operands in the execute cycle
`timescale 1ns/1ps
module operand_format_unit (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                op_valid,
  input  wire opfmt_pkg::op_sel_t  op_sel,
  input  wire logic                cmp_true,
  input  wire logic [15:0]         const_field,
  input  wire logic [7:0]          imm_field,
  input  wire logic [31:0]         dest_old,
  input  wire logic                fp_double,
  input  wire logic [63:0]         fp_a,
  input  wire logic [63:0]         fp_b,
  input  wire logic                fp_two_operands,
  input  wire logic                fp_invalid_op,
  input  wire logic                reserved_operand_en,
  output logic [31:0]              result_comb,
  output logic                     branch_taken_comb,
  output opfmt_pkg::fp_class_t     class_a_comb,
  output opfmt_pkg::fp_class_t     class_b_comb,
  output logic                     fp_nan_out_comb,
  output logic [63:0]              fp_nan_value_comb,
  output logic                     invalid_exc_comb,
  output logic                     fp_trap_comb,
  output logic                     zeros_equal_comb,
  output logic [31:0]              result_r,
  output logic                     result_valid_r,
  output logic                     invalid_exc_r,
  output logic                     fp_trap_r
);
  ////////////////////////////////////////////////////////////////////
  // classification of both operands
  opfmt_pkg::fp_class_t sa_cls;
  opfmt_pkg::fp_class_t sb_cls;
  opfmt_pkg::fp_class_t da_cls;
  opfmt_pkg::fp_class_t db_cls;
  logic                 sa_sgn;
  logic                 sb_sgn;
  logic                 da_sgn;
  logic                 db_sgn;

  fp_classifier #(
    .EXP_W  (opfmt_pkg::SP_EXP_W),
    .FRAC_W (opfmt_pkg::SP_FRAC_W)
  ) u_sa (
    .operand  (fp_a[31:0]),
    .op_class (sa_cls),
    .sign     (sa_sgn)
  );

  fp_classifier #(
    .EXP_W  (opfmt_pkg::SP_EXP_W),
    .FRAC_W (opfmt_pkg::SP_FRAC_W)
  ) u_sb (
    .operand  (fp_b[31:0]),
    .op_class (sb_cls),
    .sign     (sb_sgn)
  );

  // double operand is word pair even/odd, high word first [RL7]
  fp_classifier #(
    .EXP_W  (opfmt_pkg::DP_EXP_W),
    .FRAC_W (opfmt_pkg::DP_FRAC_W)
  ) u_da (
    .operand  (fp_a),
    .op_class (da_cls),
    .sign     (da_sgn)
  );

  fp_classifier #(
    .EXP_W  (opfmt_pkg::DP_EXP_W),
    .FRAC_W (opfmt_pkg::DP_FRAC_W)
  ) u_db (
    .operand  (fp_b),
    .op_class (db_cls),
    .sign     (db_sgn)
  );

  function automatic logic is_nan(input opfmt_pkg::fp_class_t c);
    is_nan = (c == opfmt_pkg::CLS_QUIET_NAN) ||
             (c == opfmt_pkg::CLS_SIGNALING_NAN);
  endfunction

  function automatic logic is_signaling_not_a_number(input opfmt_pkg::fp_class_t c);
    is_signaling_not_a_number = (c == opfmt_pkg::CLS_SIGNALING_NAN);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // combinational datapath, all in the execute cycle [RL18]
  logic fp_active;
  logic any_nan;
  logic any_signaling_not_a_number;

  assign fp_active = op_valid && (op_sel == opfmt_pkg::OP_FLOAT);

  always_comb
  begin
    class_a_comb = fp_double ? da_cls : sa_cls;
    class_b_comb = fp_double ? db_cls : sb_cls;
  end

  // second operand only counts for two-operand operations
  always_comb
  begin
    any_nan  = is_nan(class_a_comb) ||
               (fp_two_operands && is_nan(class_b_comb));
    any_signaling_not_a_number = is_signaling_not_a_number(class_a_comb) ||
               (fp_two_operands && is_signaling_not_a_number(class_b_comb));
  end

  always_comb
  begin
    invalid_exc_comb = fp_active && (any_signaling_not_a_number || fp_invalid_op); // [RL11]
    // trap replaces the silent default nan for nan operands when enabled [RL14]
    fp_trap_comb     = fp_active && any_nan && reserved_operand_en;
    fp_nan_out_comb  = fp_active && (any_nan || fp_invalid_op) &&
                       !fp_trap_comb;                            // [RL12]
    // default quiet nan, never a signaling one [RL13]
    if (fp_double)
      fp_nan_value_comb = opfmt_pkg::DP_DEF_QUIET_NOT_A_NUMBER;
    else
      fp_nan_value_comb = {32'h0000_0000, opfmt_pkg::SP_DEF_QUIET_NOT_A_NUMBER};
  end

  // both operands zero compare equal regardless of sign [RL17]
  assign zeros_equal_comb =
    (class_a_comb == opfmt_pkg::CLS_ZERO) &&
    (class_b_comb == opfmt_pkg::CLS_ZERO);

  // branches look only at bit 31 of the boolean word [RL1]
  assign branch_taken_comb = dest_old[opfmt_pkg::BOOL_BIT];

  always_comb
  begin
    result_comb = opfmt_pkg::RESULT_RST;
    case (op_sel)
      opfmt_pkg::OP_COMPARE:
        // lower bits cleared, msb holds truth [RL1] [RL2]
        result_comb = cmp_true ? opfmt_pkg::BOOL_TRUE
                               : opfmt_pkg::BOOL_FALSE;
      opfmt_pkg::OP_CONST_ZERO_FILL:
        result_comb = {16'h0000, const_field};            // [RL4]
      opfmt_pkg::OP_LOAD_HIGH_HALF_KEEP_LOW:
        result_comb = {const_field, dest_old[15:0]};      // [RL5]
      opfmt_pkg::OP_LOAD_LOW_HALF_ONES_FILL:
        result_comb = {16'hffff, const_field};            // [RL6]
      opfmt_pkg::OP_IMMEDIATE:
        result_comb = {24'h00_0000, imm_field};           // [RL3]
      opfmt_pkg::OP_FLOAT:
        // single nan sits in the low word, double shows its high word
        if (!fp_nan_out_comb)
          result_comb = opfmt_pkg::RESULT_RST;
        else if (fp_double)
          result_comb = fp_nan_value_comb[63:32];          // [RL13]
        else
          result_comb = fp_nan_value_comb[31:0];           // [RL13]
      default:
        result_comb = opfmt_pkg::RESULT_RST;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // registered copies for the writeback stage
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      result_r       <= opfmt_pkg::RESULT_RST;
      result_valid_r <= 1'b0;
    end
    else
    begin
      result_r       <= result_comb;
      result_valid_r <= op_valid && (op_sel != opfmt_pkg::OP_NONE);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      invalid_exc_r <= 1'b0;
      fp_trap_r     <= 1'b0;
    end
    else
    begin
      invalid_exc_r <= invalid_exc_comb;
      fp_trap_r     <= fp_trap_comb;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // exception shows at once, then in the registered copy
  sequence s_invalid_raised;
    invalid_exc_comb ##1 invalid_exc_r;
  endsequence

  // trap holds back the default nan now, then reaches writeback
  sequence s_trap_taken;
    !fp_nan_out_comb ##1 fp_trap_r;
  endsequence

  a_cmp_low_clear: assert property (                           // [RL2]
    op_valid && op_sel == opfmt_pkg::OP_COMPARE
    |=> result_r[30:0] == 31'h0000_0000 &&
        result_r[31] == $past(cmp_true))
    else $error("compare result low bits not cleared");

  a_zero_fill: assert property (                               // [RL4]
    op_valid && op_sel == opfmt_pkg::OP_CONST_ZERO_FILL
    |=> result_r == {16'h0000, $past(const_field)})
    else $error("zero fill constant wrong");

  a_high_keep: assert property (                               // [RL5]
    op_valid && op_sel == opfmt_pkg::OP_LOAD_HIGH_HALF_KEEP_LOW
    |=> result_r[15:0] == $past(dest_old[15:0]) &&
        result_r[31:16] == $past(const_field))
    else $error("high half constant wrong");

  a_ones_fill: assert property (                               // [RL6]
    op_valid && op_sel == opfmt_pkg::OP_LOAD_LOW_HALF_ONES_FILL
    |=> $signed(result_r) < 0 && result_r[31:16] == 16'hffff)
    else $error("ones fill constant wrong");

  a_signaling_not_a_number_invalid: assert property (                            // [RL11]
    fp_active && is_signaling_not_a_number(class_a_comb) |-> s_invalid_raised)
    else $error("signaling nan did not raise invalid");

  a_nan_default: assert property (                             // [RL13]
    fp_nan_out_comb && !fp_double
    |=> result_r == opfmt_pkg::SP_DEF_QUIET_NOT_A_NUMBER)
    else $error("default quiet nan wrong");

  a_trap_no_nan: assert property (                             // [RL14]
    fp_active && any_nan && reserved_operand_en
    |-> s_trap_taken)
    else $error("trap did not replace nan result");

  a_nan_class: assert property (                               // [RL9]
    !fp_double && (&fp_a[30:23]) && fp_a[22:0] != 23'h0
    |-> is_nan(class_a_comb) &&
        (class_a_comb == opfmt_pkg::CLS_QUIET_NAN) == fp_a[22])
    else $error("nan class wrong");

  a_inf_class: assert property (                               // [RL15]
    fp_double && (&fp_a[62:52]) && fp_a[51:0] == 52'h0
    |-> class_a_comb == opfmt_pkg::CLS_INFINITY)
    else $error("infinity class wrong");

  a_denorm_zero: assert property (                             // [RL16]
    !fp_double && fp_a[30:23] == 8'h00
    |-> class_a_comb == (fp_a[22:0] == 23'h0 ? opfmt_pkg::CLS_ZERO
                                             : opfmt_pkg::CLS_DENORMAL))
    else $error("denormal or zero class wrong");

  a_signaling_not_a_number_b_invalid: assert property (                          // [RL11]
    fp_active && fp_two_operands && is_signaling_not_a_number(class_b_comb)
    |-> s_invalid_raised)
    else $error("signaling nan on second operand not flagged");

  // a quiet nan alone must stay silent
  a_quiet_not_a_number_silent: assert property (                             // [RL11]
    fp_active && !fp_invalid_op && !is_signaling_not_a_number(class_a_comb) &&
    !(fp_two_operands && is_signaling_not_a_number(class_b_comb))
    |-> !invalid_exc_comb)
    else $error("exception raised without signaling nan");

  a_nan_result: assert property (                              // [RL12]
    fp_active && !reserved_operand_en &&
    (fp_invalid_op || is_nan(class_a_comb) ||
     (fp_two_operands && is_nan(class_b_comb)))
    |-> fp_nan_out_comb)
    else $error("nan or invalid operation gave no nan");

  a_sp_nan_value: assert property (                            // [RL13]
    fp_nan_out_comb && !fp_double
    |-> fp_nan_value_comb[31:0] == opfmt_pkg::SP_DEF_QUIET_NOT_A_NUMBER)
    else $error("single default nan value wrong");

  // double nan: full value now, high word after the edge
  a_dp_nan_value: assert property (                            // [RL13]
    fp_nan_out_comb && fp_double
    |-> fp_nan_value_comb == opfmt_pkg::DP_DEF_QUIET_NOT_A_NUMBER
    ##1 {result_r, 32'h0000_0000} == opfmt_pkg::DP_DEF_QUIET_NOT_A_NUMBER)
    else $error("double default nan value wrong");

  a_no_signaling_not_a_number_out: assert property (                             // [RL13]
    fp_nan_out_comb
    |-> fp_double ? fp_nan_value_comb[51] : fp_nan_value_comb[22])
    else $error("generated nan is not quiet");

  a_trap_enabled: assert property (                            // [RL14]
    fp_trap_comb |-> reserved_operand_en && fp_active)
    else $error("trap without reserved operand enable");

  // sign bit of an infinity is passed through untouched
  a_inf_sign_a: assert property (                              // [RL15]
    class_a_comb == opfmt_pkg::CLS_INFINITY
    |-> (fp_double ? da_sgn : sa_sgn) ==
        (fp_double ? fp_a[63] : fp_a[31]))
    else $error("infinity sign of first operand wrong");

  a_inf_sign_b: assert property (                              // [RL15]
    class_b_comb == opfmt_pkg::CLS_INFINITY
    |-> (fp_double ? db_sgn : sb_sgn) ==
        (fp_double ? fp_b[63] : fp_b[31]))
    else $error("infinity sign of second operand wrong");

  a_dp_normal: assert property (                               // [RL8]
    fp_double && fp_a[62:52] != 11'h000 && !(&fp_a[62:52])
    |-> class_a_comb == opfmt_pkg::CLS_NORMAL)
    else $error("double normal class wrong");

  a_dp_denorm: assert property (                               // [RL16]
    fp_double && fp_a[62:52] == 11'h000 && fp_a[51:0] != 52'h0
    |-> class_a_comb == opfmt_pkg::CLS_DENORMAL)
    else $error("double denormal class wrong");

  a_b_nan_class: assert property (                             // [RL10]
    !fp_double && (&fp_b[30:23]) && fp_b[22:0] != 23'h0
    |-> is_nan(class_b_comb) &&
        (class_b_comb == opfmt_pkg::CLS_QUIET_NAN) == fp_b[22])
    else $error("second operand nan class wrong");

  // zeros of any sign must meet as equal
  a_zero_equal: assert property (                              // [RL17]
    !fp_double && fp_a[30:0] == 31'h0 && fp_b[30:0] == 31'h0
    |-> zeros_equal_comb)
    else $error("signed zeros not treated as equal");

  a_imm_direct: assert property (                              // [RL3]
    op_valid && op_sel == opfmt_pkg::OP_IMMEDIATE
    |=> result_r == {24'h00_0000, $past(imm_field)})
    else $error("immediate not zero extended");

  // branch decision ignores every bit below the boolean one
  a_branch_msb: assert property (                              // [RL1]
    $stable(dest_old[opfmt_pkg::BOOL_BIT]) |-> $stable(branch_taken_comb))
    else $error("branch depends on low bits");

  a_result_pipe: assert property (                             // [RL18]
    1'b1 |=> result_r == $past(result_comb))
    else $error("registered result not one edge behind");

  a_valid_set: assert property (                               // [RL18]
    op_valid && op_sel != opfmt_pkg::OP_NONE |=> result_valid_r)
    else $error("valid not raised for an operation");

  a_valid_clear: assert property (                             // [RL18]
    !op_valid || op_sel == opfmt_pkg::OP_NONE |=> !result_valid_r)
    else $error("valid raised with no operation");
endmodule

// [regfile_model.sv]
// register-file stand-in that hands even/odd word pairs to the unit
// assumes the bench writes it on the rising edge of clk
`timescale 1ns/1ps
module regfile_model (
  input  wire logic        clk,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_idx,
  input  wire logic [31:0] wr_data,
  input  wire logic [2:0]  rd_idx,
  output logic [63:0]      rd_pair
);
  logic [31:0] regs_r [8];

  always_ff @(posedge clk)
  begin
    if (wr_en)
      regs_r[wr_idx] <= wr_data;
  end

  // low index bit dropped: a double always starts at an even register
  assign rd_pair = {regs_r[{rd_idx[2:1], 1'b0}],
                    regs_r[{rd_idx[2:1], 1'b1}]};
endmodule

// [operand_format_unit_tb.sv]
// self-checking bench for the operand format unit
// assumes the unit answers combinationally, registered copies one edge on
`timescale 1ns/1ps
module operand_format_unit_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic op_valid = 1'b0;
  opfmt_pkg::op_sel_t op_sel = opfmt_pkg::OP_NONE;
  logic cmp_true = 1'b0;
  logic [15:0] const_field = 16'h0000;
  logic [7:0] imm_field = 8'h00;
  logic [31:0] dest_old = 32'h0000_0000;
  logic fp_double = 1'b0;
  logic [63:0] fp_a_tb = 64'h0;
  logic [63:0] fp_b = 64'h0;
  logic fp_two_operands = 1'b0;
  logic fp_invalid_op = 1'b0;
  logic reserved_operand_en = 1'b0;
  logic use_rf = 1'b0;
  logic two_ops = 1'b1;
  logic wr_en = 1'b0;
  logic [2:0] wr_idx = 3'h0;
  logic [31:0] wr_data = 32'h0;
  logic [2:0] rd_idx = 3'h0;
  wire logic [63:0] rf_pair;
  wire logic [63:0] fp_a;
  logic [31:0] result_comb, result_r;
  logic branch_taken_comb, fp_nan_out_comb, invalid_exc_comb, fp_trap_comb;
  logic zeros_equal_comb, result_valid_r, invalid_exc_r, fp_trap_r;
  logic [63:0] fp_nan_value_comb;
  opfmt_pkg::fp_class_t class_a_comb, class_b_comb;
  int err_count = 0;
  int comparisons = 0;

  always #2.5 clk = ~clk;
  assign fp_a = use_rf ? rf_pair : fp_a_tb;

  regfile_model rf (.clk(clk), .wr_en(wr_en), .wr_idx(wr_idx),
    .wr_data(wr_data), .rd_idx(rd_idx), .rd_pair(rf_pair));

  operand_format_unit DUT (.clk(clk), .sys_rst(sys_rst),
    .op_valid(op_valid), .op_sel(op_sel), .cmp_true(cmp_true),
    .const_field(const_field), .imm_field(imm_field), .dest_old(dest_old),
    .fp_double(fp_double), .fp_a(fp_a), .fp_b(fp_b),
    .fp_two_operands(fp_two_operands), .fp_invalid_op(fp_invalid_op),
    .reserved_operand_en(reserved_operand_en), .result_comb(result_comb),
    .branch_taken_comb(branch_taken_comb), .class_a_comb(class_a_comb),
    .class_b_comb(class_b_comb), .fp_nan_out_comb(fp_nan_out_comb),
    .fp_nan_value_comb(fp_nan_value_comb),
    .invalid_exc_comb(invalid_exc_comb), .fp_trap_comb(fp_trap_comb),
    .zeros_equal_comb(zeros_equal_comb), .result_r(result_r),
    .result_valid_r(result_valid_r), .invalid_exc_r(invalid_exc_r),
    .fp_trap_r(fp_trap_r));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // comb outputs are judged 1 ns after the launching edge
  task automatic drive(input opfmt_pkg::op_sel_t s, input logic [15:0] f);
    @(posedge clk);
    op_valid <= 1'b1;
    op_sel <= s;
    const_field <= f;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_const;
    logic [15:0] f;
    dest_old <= 32'ha5a5_5a5a;
    for (int i = 0; i < 2; i++)
    begin
      f = i ? 16'hffff : 16'h0000;
      drive(opfmt_pkg::OP_CONST_ZERO_FILL, f);
      chk(result_comb, {16'h0000, f});
      drive(opfmt_pkg::OP_LOAD_HIGH_HALF_KEEP_LOW, f);
      chk(result_comb, {f, 16'h5a5a});
      drive(opfmt_pkg::OP_LOAD_LOW_HALF_ONES_FILL, f);
      chk(result_comb, {16'hffff, f});
      @(posedge clk);
      #1;
      chk({result_valid_r, result_r}, {1'b1, 16'hffff, f});
    end
    @(posedge clk);
    imm_field <= 8'hff;
    drive(opfmt_pkg::OP_IMMEDIATE, 16'h0000);
    chk(result_comb, 64'h0000_00ff);
    @(posedge clk);
    op_valid <= 1'b0;
    @(posedge clk);
    #1;
    chk(result_valid_r, 1'b0);
  endtask

  task automatic t_cmp;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      cmp_true <= i[0];
      dest_old <= i ? 32'h8000_0000 : 32'h7fff_ffff;
      drive(opfmt_pkg::OP_COMPARE, 16'hffff);
      chk(result_comb, {i[0], 31'h0});
      chk(branch_taken_comb, i[0]);
    end
  endtask

  task automatic fpc(input logic d, input logic [63:0] a, input logic [63:0] b,
                     input logic inv, input logic en,
                     input opfmt_pkg::fp_class_t ca,
                     input opfmt_pkg::fp_class_t cb,
                     input logic nan, input logic exc, input logic trap);
    @(posedge clk);
    fp_double <= d;
    fp_a_tb <= a;
    fp_b <= b;
    fp_two_operands <= two_ops;
    fp_invalid_op <= inv;
    reserved_operand_en <= en;
    drive(opfmt_pkg::OP_FLOAT, 16'h0000);
    chk(class_a_comb, ca);
    chk(class_b_comb, cb);
    chk(invalid_exc_comb, exc);
    chk(fp_trap_comb, trap);
    if (!en)
      chk(fp_nan_out_comb, nan);
    if (nan && !en)
    begin
      chk(result_comb, d ? 32'h7ffc_0000 : 32'h7fe0_0000);
      if (d)
        chk(fp_nan_value_comb, 64'h7ffc_0000_0000_0000);
      else
        chk(fp_nan_value_comb[31:0], 32'h7fe0_0000);
    end
    @(posedge clk);
    #1;
    chk({fp_trap_r, invalid_exc_r}, {trap, exc});
  endtask

  task automatic t_fp;
    fpc(0, 64'h7f80_0001, 64'h3f80_0000, 0, 0, opfmt_pkg::CLS_SIGNALING_NAN,
        opfmt_pkg::CLS_NORMAL, 1, 1, 0);
    fpc(0, 64'hffc0_0000, 64'h7f80_0000, 0, 0, opfmt_pkg::CLS_QUIET_NAN,
        opfmt_pkg::CLS_INFINITY, 1, 0, 0);
    fpc(0, 64'hff80_0000, 64'h0000_0001, 0, 0, opfmt_pkg::CLS_INFINITY,
        opfmt_pkg::CLS_DENORMAL, 0, 0, 0);
    chk(zeros_equal_comb, 1'b0);
    fpc(0, 64'h3f80_0000, 64'h3f80_0000, 1, 0, opfmt_pkg::CLS_NORMAL,
        opfmt_pkg::CLS_NORMAL, 1, 1, 0);
    // invalid operation alone never traps, only nan operands do
    fpc(0, 64'h3f80_0000, 64'h3f80_0000, 1, 1, opfmt_pkg::CLS_NORMAL,
        opfmt_pkg::CLS_NORMAL, 1, 1, 0);
    fpc(0, 64'hffc0_0000, 64'h0, 0, 1, opfmt_pkg::CLS_QUIET_NAN,
        opfmt_pkg::CLS_ZERO, 1, 0, 1);
    fpc(0, 64'h0, 64'h8000_0000, 0, 0, opfmt_pkg::CLS_ZERO,
        opfmt_pkg::CLS_ZERO, 0, 0, 0);
    chk(zeros_equal_comb, 1'b1);
    // double comes from an even/odd register pair
    @(posedge clk);
    wr_en <= 1'b1;
    wr_idx <= 3'h2;
    wr_data <= 32'h7ff0_0000;
    @(posedge clk);
    wr_idx <= 3'h3;
    wr_data <= 32'h0000_0001;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_idx <= 3'h3;
    use_rf <= 1'b1;
    fpc(1, 64'h0, 64'h0010_0000_0000_0000, 0, 0,
        opfmt_pkg::CLS_SIGNALING_NAN, opfmt_pkg::CLS_NORMAL, 1, 1, 0);
    @(posedge clk);
    use_rf <= 1'b0;
    fpc(1, 64'h000f_ffff_ffff_ffff, 64'h8000_0000_0000_0000, 0, 0,
        opfmt_pkg::CLS_DENORMAL, opfmt_pkg::CLS_ZERO, 0, 0, 0);
    // second operand ignored by one-operand operations
    two_ops = 1'b0;
    fpc(0, 64'h3f80_0000, 64'h7f80_0001, 0, 0, opfmt_pkg::CLS_NORMAL,
        opfmt_pkg::CLS_SIGNALING_NAN, 0, 0, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (11) @(posedge clk);
    #1;
    chk(result_valid_r, 1'b0);
    @(posedge clk);
    sys_rst <= 1'b0;
    t_const();
    t_cmp();
    t_fp();
    final_report();
  end

  // guards against a hang
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule
